/* core/temp_limit_status_regs.v */
// Limit, control/status and identity registers of a temperature sensor,
// reached over a two-wire serial bus with pointer addressing.
// Assumes the converter runs on clk_i and pulses conv_done_i with temp_i
// already valid; bus and alarm pins arrive asynchronously.
//
// Functional notes
// - Lower limit at 03h, resets 8000h.
// - Below lower limit releases alarm, sets flag.
// - Lower limit bits 4:0 read zero.
// - Control/status at 04h resets to 09h.
// - Bit 7 disables bus idle timeout.
// - Bits 6:5 choose conversion resolution.
// - Control/status bit 4 reads zero.
// - Bit 3 follows alarm pin level.
// - Alarm released by clear, low, response.
// - Bit 2 set when above upper.
// - Over flag clears on read once normal.
// - Bit 1 set when below lower.
// - Under flag clears on read once normal.
// - Bit 0 low while converting, high done.
// - Starts continuous; done reads one there.
// - Identity word at 07h, read only.
// - Above upper limit drives alarm active.
// - Config bit 3 clears alarm, reads zero.
// - Config bit 4 selects alarm polarity.
// - One-shot only in shutdown, reads zero.
`timescale 1ns/1ps
`include "temp_regs_defines.vh"
module temp_limit_status_regs #(
  parameter [19:0] TIMEOUT_CYC = `TIMEOUT_CYC
) (
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe_o,
  input  wire [6:0]  dev_addr_i,
  input  wire        alarm_i,
  output wire        alarm_o,
  output wire        alarm_oe_o,
  input  wire [15:0] temp_i,
  input  wire        conv_done_i,
  output wire        conv_start_o,
  output wire        shutdown_o,
  output wire [1:0]  resolution_o
);

  localparam [2:0] S_IDLE   = 3'h0;
  localparam [2:0] S_RX     = 3'h1;
  localparam [2:0] S_RX_ACK = 3'h2;
  localparam [2:0] S_TX     = 3'h3;
  localparam [2:0] S_TX_ACK = 3'h4;

  // Full-width reset words, so fields are taken by part-select
  localparam [7:0]  CFG_RST_VAL = `CONFIG_RST;
  localparam [15:0] UPR_RST_VAL = `UPPER_RST;
  localparam [15:0] LWR_RST_VAL = `LOWER_RST;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and bus edge detection

  wire [9:0] pins_s;
  wire       scl_s;
  wire       sda_s;
  wire       alarm_s;
  wire [6:0] addr_s;
  reg        scl_d_reg;
  reg        sda_d_reg;

  sync_two_ff #(
    .WIDTH   (10),
    .RST_VAL (10'h007)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .async_i ({dev_addr_i, alarm_i, sda_i, scl_i}),
    .sync_o  (pins_s)
  );

  assign scl_s   = pins_s[0];
  assign sda_s   = pins_s[1];
  assign alarm_s = pins_s[2];
  assign addr_s  = pins_s[9:3];

  // Previous samples, used for edges and start/stop
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  ////////////////////////////////////////////////////////////////////////
  // Bus idle timeout: a line held low too long resets the slave

  reg  [19:0] idle_cnt_reg;
  reg         to_off_reg;
  wire        bus_timeout = (idle_cnt_reg == TIMEOUT_CYC);

  // Counter parks at the limit so the reset stays until lines rise
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      idle_cnt_reg <= 20'h0_0000;
    end else if (to_off_reg || (scl_s && sda_s)) begin
      idle_cnt_reg <= 20'h0_0000;
    end else if (!bus_timeout) begin
      idle_cnt_reg <= idle_cnt_reg + 20'h0_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial slave state machine

  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] rx_sh_reg;
  reg [7:0] tx_sh_reg;
  reg       sda_oe_reg;
  reg       is_addr_reg;
  reg       rw_reg;
  reg       ara_reg;
  reg       nack_reg;
  reg       rd_sel_reg;
  reg [1:0] wcnt_reg;
  reg [2:0] ptr_reg;
  reg       alarm_reg;
  reg [7:0] tx_byte;

  wire rx_done  = scl_fall & (state_reg == S_RX) & (bit_cnt_reg == 4'h8);
  wire dev_hit  = (rx_sh_reg[7:1] == addr_s);
  wire ara_hit  = (rx_sh_reg[7:1] == `ARA_ADDR) & rx_sh_reg[0] & alarm_reg;
  wire load_tx  = scl_fall & (((state_reg == S_RX_ACK) & rw_reg) |
                  ((state_reg == S_TX_ACK) & ~nack_reg));
  wire data_wr  = rx_done & ~is_addr_reg;
  wire stat_rd  = load_tx & ~ara_reg & (ptr_reg == `PTR_CTRL);
  wire ara_clr  = load_tx & ara_reg;

  // Sample on SCL rise, drive on SCL fall
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      state_reg   <= S_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_sh_reg   <= 8'h00;
      tx_sh_reg   <= 8'h00;
      sda_oe_reg  <= 1'b0;
      is_addr_reg <= 1'b0;
      rw_reg      <= 1'b0;
      ara_reg     <= 1'b0;
      nack_reg    <= 1'b0;
      rd_sel_reg  <= 1'b0;
      wcnt_reg    <= 2'h0;
      ptr_reg     <= `PTR_TEMP;
    end else if (bus_stop || bus_timeout) begin
      state_reg  <= S_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (bus_start) begin
      state_reg   <= S_RX;
      bit_cnt_reg <= 4'h0;
      is_addr_reg <= 1'b1;
      sda_oe_reg  <= 1'b0;
    end else begin
      case (state_reg)
        S_RX: begin
          if (scl_rise && bit_cnt_reg != 4'h8) begin
            rx_sh_reg   <= {rx_sh_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (rx_done) begin
            bit_cnt_reg <= 4'h0;
            if (is_addr_reg) begin
              rw_reg     <= rx_sh_reg[0];
              ara_reg    <= ara_hit & ~dev_hit;
              rd_sel_reg <= 1'b0;
              wcnt_reg   <= 2'h0;
              sda_oe_reg <= dev_hit | ara_hit;
              state_reg  <= (dev_hit | ara_hit) ? S_RX_ACK : S_IDLE;
            end else begin
              if (wcnt_reg == 2'h0) begin
                ptr_reg <= rx_sh_reg[2:0];
              end
              if (wcnt_reg != 2'h3) begin
                wcnt_reg <= wcnt_reg + 2'h1;
              end
              sda_oe_reg <= 1'b1;
              state_reg  <= S_RX_ACK;
            end
          end
        end
        S_RX_ACK: begin
          if (load_tx) begin
            tx_sh_reg   <= tx_byte;
            sda_oe_reg  <= ~tx_byte[7];
            rd_sel_reg  <= ~rd_sel_reg;
            bit_cnt_reg <= 4'h0;
            state_reg   <= S_TX;
          end else if (scl_fall) begin
            sda_oe_reg  <= 1'b0;
            is_addr_reg <= 1'b0;
            state_reg   <= S_RX;
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= S_TX_ACK;
            end else begin
              tx_sh_reg   <= {tx_sh_reg[6:0], 1'b0};
              sda_oe_reg  <= ~tx_sh_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        S_TX_ACK: begin
          if (scl_rise) begin
            nack_reg <= sda_s;
          end else if (load_tx) begin
            tx_sh_reg   <= tx_byte;
            sda_oe_reg  <= ~tx_byte[7];
            rd_sel_reg  <= ~rd_sel_reg;
            bit_cnt_reg <= 4'h0;
            state_reg   <= S_TX;
          end else if (scl_fall) begin
            state_reg <= S_IDLE; // Master refused; wait for stop
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration, limits and control registers

  reg        sd_reg;
  reg        rsvd6_reg;
  reg        adis_reg;
  reg        pol_reg;
  reg  [1:0] res_reg;
  reg [10:0] upper_reg;
  reg [10:0] lower_reg;
  reg  [7:0] wbuf_reg;
  reg        start_reg;
  reg        done_reg;

  wire wr_first  = data_wr & (wcnt_reg == 2'h1);
  wire wr_second = data_wr & (wcnt_reg == 2'h2);
  wire wr_cfg    = wr_first & (ptr_reg == `PTR_CONFIG);
  wire wr_ctl    = wr_first & (ptr_reg == `PTR_CTRL);
  wire alarm_cmd = wr_cfg & rx_sh_reg[`CFG_ALARM_CLR];
  wire one_shot  = wr_cfg & rx_sh_reg[`CFG_ONE_SHOT] & sd_reg;

  // 16-bit words arrive high byte first; low byte commits the write
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      sd_reg    <= CFG_RST_VAL[`CFG_SHUTDOWN];
      rsvd6_reg <= CFG_RST_VAL[`CFG_RSVD6];
      adis_reg  <= 1'b0;
      pol_reg   <= 1'b0;
      to_off_reg <= 1'b0;
      res_reg   <= 2'h0;
      upper_reg <= UPR_RST_VAL[`LIM_MSB:`LIM_LSB];
      lower_reg <= LWR_RST_VAL[`LIM_MSB:`LIM_LSB];
      wbuf_reg  <= 8'h00;
    end else begin
      if (wr_cfg) begin
        sd_reg    <= rx_sh_reg[`CFG_SHUTDOWN];
        rsvd6_reg <= rx_sh_reg[`CFG_RSVD6];
        adis_reg  <= rx_sh_reg[`CFG_ALARM_DIS];
        pol_reg   <= rx_sh_reg[`CFG_POLARITY];
      end
      if (wr_ctl) begin
        to_off_reg <= rx_sh_reg[`CTL_TIMEOUT_OFF];
        res_reg    <= rx_sh_reg[`CTL_RES_HI:`CTL_RES_LO];
      end
      if (wr_first) begin
        wbuf_reg <= rx_sh_reg;
      end
      if (wr_second && ptr_reg == `PTR_UPPER) begin
        upper_reg <= {wbuf_reg, rx_sh_reg[7:5]};
      end
      if (wr_second && ptr_reg == `PTR_LOWER) begin
        lower_reg <= {wbuf_reg, rx_sh_reg[7:5]};
      end
    end
  end

  // One-shot request and conversion-done tracking
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      start_reg <= 1'b0;
      done_reg  <= 1'b1;
    end else begin
      start_reg <= one_shot;
      if (conv_done_i) begin
        done_reg <= 1'b1;
      end else if (one_shot) begin
        done_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Limit comparison, flags and alarm

  wire above;
  wire below;
  reg  above_reg;
  reg  below_reg;
  reg  over_reg;
  reg  under_reg;
  reg  alarm_oe_reg;

  limit_compare u_upper_cmp (
    .temp_i  (temp_i[`LIM_MSB:`LIM_LSB]),
    .limit_i (upper_reg),
    .above_o (above),
    .below_o ()
  );

  limit_compare u_lower_cmp (
    .temp_i  (temp_i[`LIM_MSB:`LIM_LSB]),
    .limit_i (lower_reg),
    .above_o (),
    .below_o (below)
  );

  wire new_above = conv_done_i & above;
  wire new_below = conv_done_i & below;

  // Results held from the last conversion; a set beats a read clear
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      above_reg <= 1'b0;
      below_reg <= 1'b0;
      over_reg  <= 1'b0;
      under_reg <= 1'b0;
    end else begin
      if (conv_done_i) begin
        above_reg <= above;
        below_reg <= below;
      end
      if (new_above) begin
        over_reg <= 1'b1;
      end else if (stat_rd && !above_reg) begin
        over_reg <= 1'b0;
      end
      if (new_below) begin
        under_reg <= 1'b1;
      end else if (stat_rd && !below_reg) begin
        under_reg <= 1'b0;
      end
    end
  end

  // Alarm state: set by over-limit, released by three sources
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      alarm_reg <= 1'b0;
    end else if (new_above) begin
      alarm_reg <= 1'b1;
    end else if (new_below || alarm_cmd || ara_clr) begin
      alarm_reg <= 1'b0;
    end
  end

  // Open-drain pin pulls low when its logical level is 0
  wire alarm_act = alarm_reg & ~adis_reg;
  wire alarm_lvl = pol_reg ? alarm_act : ~alarm_act;

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      alarm_oe_reg <= 1'b0;
    end else begin
      alarm_oe_reg <= ~alarm_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data selection

  wire [7:0] cfg_rd = {sd_reg, rsvd6_reg, adis_reg, pol_reg, 4'h0};
  wire       done_rd = sd_reg ? done_reg : 1'b1;
  // Reserved bit 4 is zero; bit 3 is the pin as seen on the wire
  wire [7:0] ctl_rd = {to_off_reg, res_reg, 1'b0, alarm_s,
                       over_reg, under_reg, done_rd};
  reg [15:0] word16;
  reg        is8;

  always @* begin
    word16 = 16'h0000;
    is8    = 1'b0;
    case (ptr_reg)
      `PTR_TEMP:   word16 = {temp_i[15:2], 2'h0};
      `PTR_CONFIG: begin
        word16 = {8'h00, cfg_rd};
        is8    = 1'b1;
      end
      `PTR_UPPER:  word16 = {upper_reg, 5'h00};
      `PTR_LOWER:  word16 = {lower_reg, 5'h00};
      `PTR_CTRL:   begin
        word16 = {8'h00, ctl_rd};
        is8    = 1'b1;
      end
      `PTR_ID:     word16 = {`ID_MAKER, `ID_PRODUCT, `ID_REVISION};
      default:     word16 = 16'h0000;
    endcase
    if (ara_reg) begin
      tx_byte = {addr_s, 1'b0};
    end else if (is8 || rd_sel_reg) begin
      tx_byte = word16[7:0];
    end else begin
      tx_byte = word16[15:8];
    end
  end

  assign sda_o        = 1'b0;
  assign sda_oe_o     = sda_oe_reg;
  assign alarm_o      = 1'b0;
  assign alarm_oe_o   = alarm_oe_reg;
  assign conv_start_o = start_reg;
  assign shutdown_o   = sd_reg;
  assign resolution_o = res_reg;

endmodule // temp_limit_status_regs

/* core/temp_regs_defines.vh */
// Constants for the limit, control/status and identity register bank.
// Included by the register bank; holds definitions only.
`ifndef TEMP_REGS_DEFINES_VH
`define TEMP_REGS_DEFINES_VH

// Register pointers
`define PTR_TEMP        3'h0
`define PTR_CONFIG      3'h1
`define PTR_UPPER       3'h2
`define PTR_LOWER       3'h3
`define PTR_CTRL        3'h4
`define PTR_ID          3'h7

// Reset values
`define CONFIG_RST      8'h40
`define UPPER_RST       16'h7FE0
`define LOWER_RST       16'h8000
`define CTRL_RST        8'h08

// Configuration fields
`define CFG_SHUTDOWN    7
`define CFG_RSVD6       6
`define CFG_ALARM_DIS   5
`define CFG_POLARITY    4
`define CFG_ALARM_CLR   3
`define CFG_ONE_SHOT    2

// Control/status fields
`define CTL_TIMEOUT_OFF 7
`define CTL_RES_HI      6
`define CTL_RES_LO      5
`define CTL_PIN_LEVEL   3
`define CTL_OVER        2
`define CTL_UNDER       1
`define CTL_DONE        0

// Limit field inside a 16-bit temperature word
`define LIM_MSB         15
`define LIM_LSB         5

// Identity word; values are arbitrary
`define ID_MAKER        8'hA5
`define ID_PRODUCT      4'h3
`define ID_REVISION     4'h2

// Alert response address
`define ARA_ADDR        7'h0C

// Timing
`define CLK_HZ          20000000
`define TIMEOUT_MS      25
// 25 ms at 20 MHz, sized to the 20-bit idle counter
`define TIMEOUT_CYC     20'd500000

`endif

/* core/sync_two_ff.v */
// Two flip-flop synchroniser for a group of asynchronous levels.
// Assumes each bit changes slowly compared with clk_i.
`timescale 1ns/1ps
module sync_two_ff #(
  parameter             WIDTH   = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             clk_i,
  input  wire             nrst_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule // sync_two_ff

/* core/limit_compare.v */
// Signed comparison of two limit fields in two's complement.
// Pure combinational; finer resolution bits are dropped by the caller.
`timescale 1ns/1ps
module limit_compare (
  input  wire [10:0] temp_i,
  input  wire [10:0] limit_i,
  output wire        above_o,
  output wire        below_o
);

  // Signed view so negative temperatures order correctly
  assign above_o = $signed(temp_i) > $signed(limit_i);
  assign below_o = $signed(temp_i) < $signed(limit_i);

endmodule // limit_compare

/* dv/temp_limit_status_regs_asserts.sv */
// Checker for the limit/status register bank, on its top ports.
// Assumes it is bound into the bank from the bench top.
`timescale 1ns/1ps
module temp_regs_checker (
  input wire       clk_i,
  input wire       nrst_i,
  input wire       scl_i,
  input wire       sda_o,
  input wire       sda_oe_o,
  input wire       alarm_o,
  input wire       alarm_oe_o,
  input wire       conv_done_i,
  input wire       conv_start_o,
  input wire       shutdown_o,
  input wire [1:0] resolution_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////
  // Cycles since SCL was low; bus-side changes may only land near it
  reg [3:0] scl_age_reg;
  always @(posedge clk_i) begin
    if (!nrst_i || !scl_i)
      scl_age_reg <= 4'h0;
    else if (scl_age_reg != 4'hF)
      scl_age_reg <= scl_age_reg + 4'h1;
  end
  // Outputs come out of reset idle, continuous, coarsest resolution
  reset_idle_a: assert property (
    $rose(nrst_i) |-> !sda_oe_o && !alarm_oe_o && !conv_start_o
      && !shutdown_o && resolution_o == 2'b00)
    else $error("outputs not idle after reset");
  open_drain_a: assert property (!sda_o && !alarm_o)
    else $error("open drain value not low");
  sda_edge_a: assert property ($changed(sda_oe_o) |-> scl_age_reg < 4'd6)
    else $error("data line moved while clock high");
  res_cause_a: assert property (
    $changed(resolution_o) |-> scl_age_reg < 4'd8)
    else $error("resolution changed without bus write");
  shut_cause_a: assert property (
    $changed(shutdown_o) |-> scl_age_reg < 4'd8)
    else $error("shutdown changed without bus write");
  start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
    else $error("one-shot request longer than a cycle");
  start_mode_a: assert property (
    conv_start_o |-> $past(shutdown_o) && scl_age_reg < 4'd8)
    else $error("one-shot request outside shutdown");
  // Alarm moves two edges after a conversion, or from a bus command
  alarm_cause_a: assert property (
    $changed(alarm_oe_o) |-> $past(conv_done_i, 2) || scl_age_reg < 4'd8)
    else $error("alarm moved without cause");
  cover property (conv_start_o);
  cover property ($rose(alarm_oe_o));
  cover property ($changed(resolution_o));
endmodule // temp_regs_checker

/* dv/temp_bus_host.sv */
// Host model for the two-wire bus: start, stop, bytes, register access.
// Assumes pull-ups; the bench resolves the data wire from both enables.
`timescale 1ns/1ps
module temp_bus_host (
  input  wire clk_i,
  input  wire sda_i,
  output reg  scl_o,
  output reg  sda_low_o
);
  integer nack_cnt;
  // Clock stands high and data released between frames
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    nack_cnt = 0;
  end
  ////////////////////////////////
  task ph(input integer n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
    end
  endtask
  // Data moves a cycle into SCL low; sampled at the end of SCL high
  task bit_io(input b, output r);
    begin
      scl_o = 1'b0;
      ph(1);
      sda_low_o = !b;
      ph(3);
      scl_o = 1'b1;
      ph(4);
      r = sda_i;
    end
  endtask
  // Long low phase lets the device drop its last bit first
  task start;
    begin
      scl_o = 1'b0;
      ph(1);
      sda_low_o = 1'b0;
      ph(7);
      scl_o = 1'b1;
      ph(4);
      sda_low_o = 1'b1;
      ph(4);
    end
  endtask
  task stop;
    begin
      scl_o = 1'b0;
      ph(1);
      sda_low_o = 1'b1;
      ph(7);
      scl_o = 1'b1;
      ph(4);
      sda_low_o = 1'b0;
      ph(8);
    end
  endtask
  // A missing acknowledge is counted where one is due
  task byte_io(input [7:0] d, input ack_i, input chk, output [7:0] q);
    integer i;
    reg     a;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(d[i], q[i]);
      bit_io(ack_i, a);
      if (chk && a)
        nack_cnt = nack_cnt + 1;
    end
  endtask
  task wr(input [6:0] a, input [2:0] p, input [15:0] d, input integer n);
    reg [7:0] q;
    integer   k;
    begin
      start;
      byte_io({a, 1'b0}, 1'b1, 1'b1, q);
      byte_io({5'h00, p}, 1'b1, 1'b1, q);
      for (k = n; k > 0; k = k - 1)
        byte_io(d[8*k-1 -: 8], 1'b1, 1'b1, q);
      stop;
    end
  endtask
  // Reads n bytes from the current pointer, refusing the last
  task rd_raw(input [6:0] a, input integer n, output [15:0] d);
    reg [7:0] q;
    integer   k;
    begin
      start;
      byte_io({a, 1'b1}, 1'b1, 1'b1, q);
      d = 16'h0000;
      for (k = n; k > 0; k = k - 1) begin
        byte_io(8'hFF, k == 1, 1'b0, q);
        d = {d[7:0], q};
      end
      stop;
    end
  endtask
  // Leaves the clock stuck low in the acknowledge slot of an address
  task hang(input [6:0] a);
    reg [7:0] b;
    reg       r;
    integer   i;
    begin
      b = {a, 1'b0};
      start;
      for (i = 7; i >= 0; i = i - 1)
        bit_io(b[i], r);
      scl_o = 1'b0;
      ph(1);
    end
  endtask
  // Finishes the acknowledge slot and closes the frame
  task unhang;
    reg r;
    begin
      bit_io(1'b1, r);
      stop;
    end
  endtask
  task rd(input [6:0] a, input [2:0] p, input integer n, output [15:0] d);
    reg [7:0] q;
    begin
      start;
      byte_io({a, 1'b0}, 1'b1, 1'b1, q);
      byte_io({5'h00, p}, 1'b1, 1'b1, q);
      rd_raw(a, n, d);
    end
  endtask
endmodule // temp_bus_host

/* dv/temp_limit_status_regs_test.sv */
// Bench for the limit/status register bank, driven over the bus.
// Assumes the bank, its helpers, the host model and checker compiled.
`timescale 1ns/1ps
`include "temp_regs_defines.vh"
module temp_limit_status_regs_test;
  localparam [6:0] DEV = 7'h48;
  reg         clk_i;
  reg         nrst_i;
  reg  [15:0] temp_i;
  reg         conv_done_i;
  wire        scl_w;
  wire        host_low;
  wire        sda_o;
  wire        sda_oe_o;
  wire        alarm_o;
  wire        alarm_oe_o;
  wire        conv_start_o;
  wire        shutdown_o;
  wire [1:0]  resolution_o;
  integer     bad_count;
  integer     compares;
  integer     cycles;
  integer     starts;
  integer     i;
  reg  [15:0] q;
  // Open-drain wires with pull-ups
  wire sda_w = !host_low && (sda_oe_o ? sda_o : 1'b1);
  wire alarm_w = alarm_oe_o ? alarm_o : 1'b1;
  temp_limit_status_regs #(.TIMEOUT_CYC(20'd200)) u_temp_limit_status_regs (
    .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_w), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .dev_addr_i(DEV),
    .alarm_i(alarm_w), .alarm_o(alarm_o), .alarm_oe_o(alarm_oe_o),
    .temp_i(temp_i), .conv_done_i(conv_done_i),
    .conv_start_o(conv_start_o), .shutdown_o(shutdown_o),
    .resolution_o(resolution_o));
  temp_bus_host u_temp_bus_host (.clk_i(clk_i), .sda_i(sda_w),
    .scl_o(scl_w), .sda_low_o(host_low));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  ////////////////////////////////
  // Cycle ceiling cuts a hang short; one-shot pulses are counted
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (conv_start_o === 1'b1)
      starts = starts + 1;
    if (cycles == 60000) begin
      bad_count = bad_count + 1;
      tally_and_finish;
    end
  end
  task check(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task w(input [2:0] p, input [15:0] d, input integer n);
    u_temp_bus_host.wr(DEV, p, d, n);
  endtask
  task r(input [2:0] p, input integer n);
    u_temp_bus_host.rd(DEV, p, n, q);
  endtask
  // One conversion result, then time for flags and alarm to settle
  task conv(input [15:0] t);
    begin
      temp_i = t;
      conv_done_i = 1'b1;
      @(posedge clk_i);
      #1;
      conv_done_i = 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
    end
  endtask
  // Clock held low while the device acknowledges; idle timer decides
  task stuck(input exp);
    begin
      u_temp_bus_host.hang(DEV);
      repeat (250) @(posedge clk_i);
      #1;
      check(sda_oe_o, exp);
      u_temp_bus_host.unhang;
    end
  endtask
  initial begin
    nrst_i = 1'b0;
    temp_i = 16'h0000;
    conv_done_i = 1'b0;
    bad_count = 0;
    compares = 0;
    cycles = 0;
    starts = 0;
    repeat (2) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    r(`PTR_LOWER, 2);
    check(q, 16'h8000);
    r(`PTR_CTRL, 1);
    check(q & 16'h00FE, 16'h0008);
    check(q[0], 1'b1);
    w(`PTR_ID, 16'h0000, 2);
    r(`PTR_ID, 2);
    check(q, {`ID_MAKER, `ID_PRODUCT, `ID_REVISION});
    w(`PTR_LOWER, 16'h081F, 2);
    r(`PTR_LOWER, 2);
    check(q, 16'h0800);
    // Every resolution code; the last also turns the idle timeout off
    for (i = 0; i < 4; i = i + 1) begin
      w(`PTR_CTRL, {8'h00, i == 3, i[1:0], 5'h10}, 1);
      check(resolution_o, i[1:0]);
      r(`PTR_CTRL, 1);
      check(q[7:4], {i == 3, i[1:0], 1'b0});
    end
    stuck(1'b1);
    w(`PTR_CTRL, 16'h0000, 1);
    stuck(1'b0);
    w(`PTR_UPPER, 16'h1900, 2);
    conv(16'h191F);
    check(alarm_oe_o, 1'b0);
    conv(16'h1920);
    check(alarm_oe_o, 1'b1);
    r(`PTR_CTRL, 1);
    check(q[3:0], 4'b0101);
    r(`PTR_CTRL, 1);
    check(q[3:0], 4'b0101);
    conv(16'h1000);
    check(alarm_oe_o, 1'b1);
    r(`PTR_CTRL, 1);
    check(q[2], 1'b1);
    r(`PTR_CTRL, 1);
    check(q[3:0], 4'b0001);
    w(`PTR_CONFIG, 16'h0048, 1);
    check(alarm_oe_o, 1'b0);
    r(`PTR_CONFIG, 1);
    check(q[7:0], 8'h40);
    r(`PTR_CTRL, 1);
    check(q[3], 1'b1);
    // Signed compare: a negative reading is below a positive limit
    conv(16'h1920);
    conv(16'hF000);
    check(alarm_oe_o, 1'b0);
    r(`PTR_CTRL, 1);
    check(q[3:0], 4'b1111);
    r(`PTR_CTRL, 1);
    check(q[3:0], 4'b1011);
    conv(16'h0800);
    r(`PTR_CTRL, 1);
    check(q[3:0], 4'b1011);
    r(`PTR_CTRL, 1);
    check(q[3:0], 4'b1001);
    // Alert response: refused with no alarm, answered and cleared with one
    u_temp_bus_host.rd_raw(7'h0C, 1, q);
    check(u_temp_bus_host.nack_cnt, 16'h0001);
    conv(16'h1920);
    // A disabled alarm leaves the pin released; re-enabling restores it
    w(`PTR_CONFIG, 16'h0060, 1);
    check(alarm_oe_o, 1'b0);
    w(`PTR_CONFIG, 16'h0040, 1);
    check(alarm_oe_o, 1'b1);
    u_temp_bus_host.rd_raw(7'h0C, 1, q);
    check(q[7:0], {DEV, 1'b0});
    check(alarm_oe_o, 1'b0);
    w(`PTR_CONFIG, 16'h0050, 1);
    check(alarm_oe_o, 1'b1);
    r(`PTR_CTRL, 1);
    check(q[3], 1'b0);
    w(`PTR_CONFIG, 16'h0044, 1);
    check(alarm_oe_o, 1'b0);
    check(starts, 16'h0000);
    w(`PTR_CONFIG, 16'h00C0, 1);
    w(`PTR_CONFIG, 16'h00C4, 1);
    check({shutdown_o, starts[0]}, 2'b11);
    r(`PTR_CTRL, 1);
    check(q[0], 1'b0);
    conv(16'h0C00);
    r(`PTR_CTRL, 1);
    check(q[0], 1'b1);
    w(`PTR_CONFIG, 16'h0040, 1);
    check({shutdown_o, starts[1:0]}, 3'b001);
    check(u_temp_bus_host.nack_cnt, 16'h0001);
    tally_and_finish;
  end
endmodule // temp_limit_status_regs_test
bind temp_limit_status_regs temp_regs_checker u_temp_regs_checker (
  .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .alarm_o(alarm_o), .alarm_oe_o(alarm_oe_o),
  .conv_done_i(conv_done_i), .conv_start_o(conv_start_o),
  .shutdown_o(shutdown_o), .resolution_o(resolution_o));
